// *** logic/touch_key_map.vh ***
`ifndef TOUCH_KEY_MAP_VH
`define TOUCH_KEY_MAP_VH
`define TK_NKEYS          10
`define TK_ADDR_CTRL      4'h0
`define TK_ADDR_STAT      4'h4
`define TK_CTRL_RST       8'h00
`define TK_C_FAST         2
`define TK_C_AKS          3
`define TK_C_AKS_ALL      4
`define TK_C_SYNC         5
`define TK_C_SLEEP        6
`define TK_C_SIMPLE       7
`define TK_RECAL_OFF      2'h0
`define TK_RECAL_SHORT    2'h1
`define TK_RECAL_LONG     2'h2
`define TK_CLK_HZ         100000000
`define TK_TICK_MS        500
`define TK_RECAL_SHORT_MS 10000
`define TK_RECAL_LONG_MS  60000
`define TK_NEG_RECAL_MS   2000
`define TK_DRIFT_UP_MS    2000
`define TK_DRIFT_DN_MS    500
`define TK_SLEEP_GAP_MS   100
`define TK_FULL_GAP_CYC   32'h00000010
`define TK_DI_NORM        3'h6
`define TK_DI_FAST        3'h2
`define TK_TOUCH_TH       13'h000a
`define TK_NEG_TH         13'h000a
`define TK_LFSR_SEED      7'h01
`define TK_RX_SKIP_BITS   5'h09
`define TK_TX_BITS        5'h13
`endif

// *** logic/touch_key_ctrl.v ***
`timescale 1ns/10ps
`include "touch_key_map.vh"
module touch_key_ctrl #(
  parameter TICK_CYC      = `TK_TICK_MS * (`TK_CLK_HZ / 1000),
  parameter SLEEP_GAP_CYC = `TK_SLEEP_GAP_MS * (`TK_CLK_HZ / 1000)
) (
  input  wire        core_clk_i,
  input  wire        nrst_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [15:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [15:0] reg_rdata_o,
  output reg         burst_go_o,
  output reg  [1:0]  burst_sel_o,
  output wire [3:0]  spread_code_o,
  input  wire        burst_done_i,
  input  wire        sample_vld_i,
  input  wire [3:0]  sample_key_i,
  input  wire [11:0] sample_val_i,
  input  wire        line_lock_and_sleep_pin_i,
  output reg         sleep_idle_o,
  output reg         touch_wake_o,
  output reg  [9:0]  key_state_o,
  output reg         change_n_o,
  output reg         cal_done_o,
  input  wire        ser_rx_i,
  output reg         ser_tx_o,
  output reg         ser_tx_oe_o
);
  localparam [15:0] T_REC_S = `TK_RECAL_SHORT_MS / `TK_TICK_MS;
  localparam [15:0] T_REC_L = `TK_RECAL_LONG_MS / `TK_TICK_MS;
  localparam [15:0] T_NEG   = `TK_NEG_RECAL_MS / `TK_TICK_MS;
  localparam [15:0] T_UP    = `TK_DRIFT_UP_MS / `TK_TICK_MS;
  localparam [15:0] T_DN    = `TK_DRIFT_DN_MS / `TK_TICK_MS;
  localparam [1:0] S_WAIT = 2'h0, S_GO = 2'h1, S_BUSY = 2'h2, S_GAP = 2'h3;
  localparam [1:0] U_IDLE = 2'h0, U_MEAS = 2'h1, U_SKIP = 2'h2, U_TX = 2'h3;

  function [1:0] grp;
    input [3:0] n;
    begin
      grp = (n >= 4'h8) ? 2'h2 : {1'b0, n[1]};
    end
  endfunction

  reg  [7:0]  ctrl_r;
  reg  [31:0] div_r;
  reg  [15:0] tick_r;
  reg  [1:0]  st_r;
  reg  [31:0] gap_r;
  reg  [6:0]  lfsr_r;
  reg         pin_s1_r, pin_s2_r, pin_s3_r;
  reg         rx_s1_r, rx_s2_r;
  reg         sleep_act_r;
  reg  [9:0]  cal_pend_r;
  reg  [9:0]  neg_r;
  reg  [9:0]  dval_r;
  reg  [11:0] ref_m [0:9];
  reg  [2:0]  integ_m [0:9];
  reg  [15:0] tstamp_m [0:9];
  reg  [15:0] negst_m [0:9];
  reg  [15:0] dstamp_m [0:9];
  reg  [129:0] dflat_r;
  reg  [1:0]  u_r;
  reg  [15:0] baud_r, bcnt_r;
  reg  [4:0]  bits_r;
  reg  [19:0] sh_r;
  reg         tx_done;

  // Effective configuration
  wire       simple   = ctrl_r[`TK_C_SIMPLE];
  wire       aks_on   = ctrl_r[`TK_C_AKS];
  wire       aks_all  = ctrl_r[`TK_C_AKS_ALL];
  wire       sleep_en = ctrl_r[`TK_C_SLEEP];
  wire [1:0] rsel     = simple ? `TK_RECAL_LONG : ctrl_r[1:0];
  wire       fast_on  = ctrl_r[`TK_C_FAST] & ~aks_on & ~simple;
  wire       sync_on  = ctrl_r[`TK_C_SYNC] & ~sleep_en & ~simple;
  wire       pin_edge = pin_s2_r & ~pin_s3_r;
  wire [15:0] rec_lim = (rsel == `TK_RECAL_SHORT) ? T_REC_S :
                        (rsel == `TK_RECAL_LONG) ? T_REC_L : 16'h0000;

  // Current sample
  wire [3:0]  k      = sample_key_i;
  wire        kv     = sample_vld_i && (k < 4'ha);
  wire [11:0] cur_ref = ref_m[k];
  wire [2:0]  cur_int = integ_m[k];
  wire [12:0] delta  = {1'b0, cur_ref} - {1'b0, sample_val_i};
  wire [12:0] ndelta = {1'b0, sample_val_i} - {1'b0, cur_ref};
  wire        over   = ~delta[12] && (delta >= `TK_TOUCH_TH);
  wire        negdir = delta[12] && (ndelta >= `TK_NEG_TH);
  wire [15:0] age    = tick_r - tstamp_m[k];
  wire [15:0] nage   = tick_r - negst_m[k];
  wire [15:0] dage   = tick_r - dstamp_m[k];
  wire [9:0]  beat;

  // A stronger detecting key in the same group, or in any group when aks_all is set, outvotes this one
  genvar j;
  generate
    for (j = 0; j < 10; j = j + 1) begin : g_aks
      localparam [3:0] JJ = j;
      wire [12:0] dj = dflat_r[j*13 +: 13];
      assign beat[j] = aks_on && (JJ != k) && dval_r[j] &&
                       (aks_all || (grp(JJ) == grp(k))) &&
                       ~dj[12] && (dj >= `TK_TOUCH_TH) &&
                       ((dj > delta) || ((dj == delta) && (JJ < k)));
    end
  endgenerate

  wire touch = over && ~|beat;

  reg [11:0] ref_nxt;
  reg [2:0]  int_nxt;
  reg        st_nxt, recal, stamp_on, dset;
  always @* begin
    ref_nxt  = cur_ref;
    int_nxt  = cur_int;
    st_nxt   = key_state_o[k];
    recal    = 1'b0;
    stamp_on = 1'b0;
    dset     = 1'b0;
    if (cal_pend_r[k]) begin
      ref_nxt = sample_val_i;
      int_nxt = 3'h0;
      st_nxt  = 1'b0;
      dset    = 1'b1;
    end else if ((rec_lim != 16'h0000) && key_state_o[k] && (age >= rec_lim)) begin
      recal   = 1'b1;
      st_nxt  = 1'b0;
      int_nxt = 3'h0;
    end else if (neg_r[k] && negdir && (nage >= T_NEG)) begin
      recal   = 1'b1;
      st_nxt  = 1'b0;
      int_nxt = 3'h0;
    end else begin
      if (!key_state_o[k]) begin
        if (touch) begin
          if ((cur_int + 3'h1) >= (fast_on ? `TK_DI_FAST : `TK_DI_NORM)) begin
            st_nxt   = 1'b1;
            int_nxt  = 3'h0;
            stamp_on = 1'b1;
          end else begin
            int_nxt = cur_int + 3'h1;
          end
        end else begin
          int_nxt = 3'h0;
        end
      end else begin
        if (!touch) begin
          if ((cur_int + 3'h1) >= `TK_DI_NORM) begin
            st_nxt  = 1'b0;
            int_nxt = 3'h0;
          end else begin
            int_nxt = cur_int + 3'h1;
          end
        end else begin
          int_nxt = 3'h0;
        end
      end
      // Drift only while idle so a slow touch is not absorbed
      if (!key_state_o[k] && !over) begin
        if (~delta[12] && (delta != 13'h0000) && (dage >= T_UP)) begin
          ref_nxt = cur_ref - 12'h001;
          dset    = 1'b1;
        end else if (delta[12] && (dage >= T_DN)) begin
          ref_nxt = cur_ref + 12'h001;
          dset    = 1'b1;
        end
      end
    end
  end

  wire onset = kv && st_nxt && !key_state_o[k];

  // Per-key memories, no reset: cal_pend_r gates their first use, dval_r that of dflat_r
  always @(posedge core_clk_i) begin
    if (kv) begin
      ref_m[k]   <= ref_nxt;
      integ_m[k] <= int_nxt;
      dflat_r[k*13 +: 13] <= delta;
      if (stamp_on) begin
        tstamp_m[k] <= tick_r;
      end
      if (negdir && !neg_r[k]) begin
        negst_m[k] <= tick_r;
      end
      if (dset) begin
        dstamp_m[k] <= tick_r;
      end
    end
  end

  // Key state, calibration and change flag
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_state_o <= 10'h000;
      cal_pend_r  <= 10'h3ff;
      neg_r       <= 10'h000;
      dval_r      <= 10'h000;
      cal_done_o  <= 1'b0;
      change_n_o  <= 1'b1;
    end else begin
      if (kv) begin
        key_state_o[k] <= st_nxt;
        cal_pend_r[k]  <= recal;
        neg_r[k]       <= negdir && !cal_pend_r[k];
        dval_r[k]      <= 1'b1;
      end
      cal_done_o <= ~|cal_pend_r;
      // Key change wins over the clear at reply end
      if (kv && (st_nxt != key_state_o[k])) begin
        change_n_o <= 1'b0;
      end else if (tx_done) begin
        change_n_o <= 1'b1;
      end
    end
  end

  // Register port, time base, pin synchronisers
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r      <= `TK_CTRL_RST;
      reg_rdata_o <= 16'h0000;
      div_r       <= 32'h00000000;
      tick_r      <= 16'h0000;
      pin_s1_r    <= 1'b0;
      pin_s2_r    <= 1'b0;
      pin_s3_r    <= 1'b0;
      rx_s1_r     <= 1'b1;
      rx_s2_r     <= 1'b1;
    end else begin
      pin_s1_r <= line_lock_and_sleep_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      rx_s1_r  <= ser_rx_i;
      rx_s2_r  <= rx_s1_r;
      if (div_r >= TICK_CYC - 1) begin
        div_r  <= 32'h00000000;
        tick_r <= tick_r + 16'h0001;
      end else begin
        div_r <= div_r + 32'h00000001;
      end
      if (reg_wr_i && (reg_addr_i == `TK_ADDR_CTRL)) begin
        ctrl_r <= reg_wdata_i[7:0];
      end
      reg_rdata_o <= 16'h0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `TK_ADDR_CTRL: reg_rdata_o <= {8'h00, ctrl_r};
          `TK_ADDR_STAT: reg_rdata_o <= {3'h0, ~change_n_o, sleep_act_r,
                                         cal_done_o, key_state_o};
          default:       reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // Burst sequencer, sleep and wake
  assign spread_code_o = lfsr_r[3:0];
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r         <= S_GO;
      burst_go_o   <= 1'b0;
      burst_sel_o  <= 2'h0;
      gap_r        <= 32'h00000000;
      lfsr_r       <= `TK_LFSR_SEED;
      sleep_act_r  <= 1'b0;
      touch_wake_o <= 1'b0;
      sleep_idle_o <= 1'b0;
    end else begin
      burst_go_o <= 1'b0;
      case (st_r)
        S_WAIT: begin
          if (!sync_on || pin_edge) begin
            st_r <= S_GO;
          end
        end
        S_GO: begin
          burst_go_o <= 1'b1;
          lfsr_r     <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
          st_r       <= S_BUSY;
        end
        S_BUSY: begin
          if (burst_done_i) begin
            if (burst_sel_o != 2'h2) begin
              burst_sel_o <= burst_sel_o + 2'h1;
              st_r        <= S_GO;
            end else begin
              burst_sel_o <= 2'h0;
              gap_r       <= 32'h00000000;
              st_r        <= sync_on ? S_WAIT : S_GAP;
            end
          end
        end
        S_GAP: begin
          gap_r <= gap_r + 32'h00000001;
          if (sleep_act_r ? (gap_r >= SLEEP_GAP_CYC - 1) :
              (gap_r >= `TK_FULL_GAP_CYC - 32'h00000001)) begin
            st_r <= S_GO;
          end
        end
        default: st_r <= S_WAIT;
      endcase
      sleep_idle_o <= sleep_act_r && (st_r == S_GAP);
      if (!sleep_en) begin
        sleep_act_r  <= 1'b0;
        touch_wake_o <= 1'b0;
      end else if (onset && sleep_act_r) begin
        sleep_act_r  <= 1'b0;
        touch_wake_o <= 1'b1;
      end else if (pin_edge) begin
        sleep_act_r  <= 1'b1;
        touch_wake_o <= 1'b0;
      end
    end
  end

  // Serial slave: start bit length sets baud, reply follows request
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      u_r         <= U_IDLE;
      baud_r      <= 16'h0001;
      bcnt_r      <= 16'h0000;
      bits_r      <= 5'h00;
      sh_r        <= 20'hfffff;
      ser_tx_o    <= 1'b1;
      ser_tx_oe_o <= 1'b0;
      tx_done     <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      case (u_r)
        U_IDLE: begin
          if (!rx_s2_r) begin
            bcnt_r <= 16'h0001;
            u_r    <= U_MEAS;
          end
        end
        U_MEAS: begin
          if (rx_s2_r) begin
            baud_r <= bcnt_r;
            bcnt_r <= 16'h0000;
            bits_r <= 5'h00;
            u_r    <= U_SKIP;
          end else if (bcnt_r != 16'hffff) begin
            bcnt_r <= bcnt_r + 16'h0001;
          end
        end
        U_SKIP: begin
          if (bcnt_r >= baud_r - 16'h0001) begin
            bcnt_r <= 16'h0000;
            bits_r <= bits_r + 5'h01;
            if (bits_r == `TK_RX_SKIP_BITS - 5'h01) begin
              sh_r <= {1'b1, cal_done_o, sleep_act_r, 4'h0, key_state_o[9:8],
                       1'b0, 1'b1, key_state_o[7:0], 1'b0};
              ser_tx_o    <= 1'b0;
              ser_tx_oe_o <= 1'b1;
              bits_r      <= 5'h00;
              u_r         <= U_TX;
            end
          end else begin
            bcnt_r <= bcnt_r + 16'h0001;
          end
        end
        U_TX: begin
          if (bcnt_r >= baud_r - 16'h0001) begin
            bcnt_r <= 16'h0000;
            bits_r <= bits_r + 5'h01;
            sh_r   <= {1'b1, sh_r[19:1]};
            ser_tx_o <= sh_r[1];
            if (bits_r == `TK_TX_BITS) begin
              ser_tx_o    <= 1'b1;
              ser_tx_oe_o <= 1'b0;
              tx_done     <= 1'b1;
              u_r         <= U_IDLE;
            end
          end else begin
            bcnt_r <= bcnt_r + 16'h0001;
          end
        end
        default: u_r <= U_IDLE;
      endcase
    end
  end
endmodule

// *** testbench/touch_key_ctrl_asserts.sv ***
`timescale 1ns/10ps
module touch_key_ctrl_asserts (
  input wire        core_clk_i,
  input wire        nrst_i,
  input wire [3:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        burst_go_o,
  input wire [1:0]  burst_sel_o,
  input wire        sample_vld_i,
  input wire        sleep_idle_o,
  input wire        touch_wake_o,
  input wire [9:0]  key_state_o,
  input wire        change_n_o,
  input wire        cal_done_o,
  input wire        ser_tx_o,
  input wire        ser_tx_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  reg [1:0] last_r;
  reg [7:0] ctrl_r;
  // Starts at 2 so the first burst must be group 0
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_r <= 2'h2;
      ctrl_r <= 8'h00;
    end else begin
      if (burst_go_o)
        last_r <= burst_sel_o;
      if (reg_wr_i && reg_addr_i == 4'h0)
        ctrl_r <= reg_wdata_i[7:0];
    end
  end
  burst_order_a: assert property (
    burst_go_o |-> burst_sel_o == ((last_r == 2'h2) ? 2'h0 : last_r + 2'h1))
    else $error("burst group out of order");
  go_pulse_a: assert property (
    burst_go_o |=> !burst_go_o && $stable(burst_sel_o) && burst_sel_o != 2'h3)
    else $error("burst start not a clean pulse");
  cal_gate_a: assert property (
    !cal_done_o |-> key_state_o == 10'h000)
    else $error("key reported before calibration");
  // Every key state update needs a sample; checked only with timed recalibration off
  state_cause_a: assert property (
    (ctrl_r[1:0] == 2'h0 && !ctrl_r[7] && $changed(key_state_o))
      |-> $past(sample_vld_i) || $past(sample_vld_i, 2) || $past(sample_vld_i, 3))
    else $error("key state moved without a sample");
  change_flag_a: assert property (
    $changed(key_state_o) |-> ##[0:2] !change_n_o)
    else $error("state change not flagged");
  idle_gap_a: assert property (
    $rose(sleep_idle_o) |-> !burst_go_o [*8])
    else $error("burst inside sleep gap");
  wake_touch_a: assert property (
    $rose(touch_wake_o) |-> ##[0:2] (key_state_o != 10'h000 && !sleep_idle_o))
    else $error("wake without touch");
  tx_idle_a: assert property (
    !ser_tx_oe_o |-> ser_tx_o)
    else $error("serial line not idle high");
  tx_start_a: assert property (
    $rose(ser_tx_oe_o) |-> !ser_tx_o)
    else $error("reply without start bit");
  cover property (touch_wake_o);
  cover property ($fell(change_n_o));
  cover property (burst_go_o && burst_sel_o == 2'h2);
endmodule

bind touch_key_ctrl touch_key_ctrl_asserts touch_key_ctrl_asserts_inst (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .burst_go_o(burst_go_o),
  .burst_sel_o(burst_sel_o), .sample_vld_i(sample_vld_i), .sleep_idle_o(sleep_idle_o),
  .touch_wake_o(touch_wake_o), .key_state_o(key_state_o), .change_n_o(change_n_o),
  .cal_done_o(cal_done_o), .ser_tx_o(ser_tx_o), .ser_tx_oe_o(ser_tx_oe_o));

// *** testbench/sense_front_model.sv ***
`timescale 1ns/10ps
module sense_front_model (
  input  wire        clk_i,
  input  wire        go_i,
  input  wire [1:0]  sel_i,
  input  wire [9:0]  touch_i,
  input  wire        slow_i,
  output reg         done_o,
  output reg         vld_o,
  output reg  [3:0]  key_o,
  output reg  [11:0] val_o
);
  integer   i;
  reg [3:0] k;
  function [3:0] key_of(input [1:0] g, input [1:0] n);
    case (g)
      2'h0: key_of = n[1] ? {3'h2, n[0]} : {2'h0, n};
      2'h1: key_of = n[1] ? {3'h2, n[0]} + 4'h2 : {2'h0, n} + 4'h2;
      default: key_of = n[1] ? 4'hf : {2'h2, n};
    endcase
  endfunction
  initial begin
    done_o = 1'b0;
    vld_o = 1'b0;
    key_o = 4'h0;
    val_o = 12'h000;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        repeat (slow_i ? 9 : 1) @(posedge clk_i);
        for (i = 0; i < 4; i++) begin
          k = key_of(sel_i, i[1:0]);
          if (k != 4'hf) begin
            vld_o <= 1'b1;
            key_o <= k;
            // Higher keys drop further, so they win suppression
            val_o <= touch_i[k] ? 12'h12c - {5'h0, k, 3'h0} : 12'h190;
            @(posedge clk_i);
          end
        end
        // Released lines move, never hold a stale sample
        vld_o <= 1'b0;
        key_o <= ~key_o;
        val_o <= ~val_o;
        done_o <= 1'b1;
        @(posedge clk_i);
        done_o <= 1'b0;
      end
    end
  end
endmodule

// *** testbench/touch_key_ctrl_test.sv ***
`timescale 1ns/10ps
module touch_key_ctrl_test;
  logic        core_clk_i, nrst_i, reg_wr_i, reg_rd_i, burst_done_i, sample_vld_i;
  logic        line_lock_and_sleep_pin_i, ser_rx_i, burst_go_o, sleep_idle_o;
  logic        touch_wake_o, change_n_o, cal_done_o, ser_tx_o, ser_tx_oe_o, slow;
  logic [3:0]  reg_addr_i, sample_key_i, spread_code_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, d;
  logic [11:0] sample_val_i;
  logic [1:0]  burst_sel_o;
  logic [9:0]  key_state_o, touch, v, fr;
  integer      seed, n_mismatch, tests_run, cyc, cnt, gcnt, wk, k, b, i;
  touch_key_ctrl #(.TICK_CYC(100), .SLEEP_GAP_CYC(50)) touch_key_ctrl_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .burst_go_o(burst_go_o), .burst_sel_o(burst_sel_o),
    .spread_code_o(spread_code_o), .burst_done_i(burst_done_i),
    .sample_vld_i(sample_vld_i), .sample_key_i(sample_key_i), .sample_val_i(sample_val_i),
    .line_lock_and_sleep_pin_i(line_lock_and_sleep_pin_i), .sleep_idle_o(sleep_idle_o),
    .touch_wake_o(touch_wake_o), .key_state_o(key_state_o), .change_n_o(change_n_o),
    .cal_done_o(cal_done_o), .ser_rx_i(ser_rx_i), .ser_tx_o(ser_tx_o),
    .ser_tx_oe_o(ser_tx_oe_o));
  sense_front_model sense_front_model_inst (.clk_i(core_clk_i), .go_i(burst_go_o),
    .sel_i(burst_sel_o), .touch_i(touch), .slow_i(slow), .done_o(burst_done_i),
    .vld_o(sample_vld_i), .key_o(sample_key_i), .val_o(sample_val_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Counts samples of the watched key that agree with its new touch level
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (burst_go_o)
      gcnt <= gcnt + 1;
    if (sample_vld_i && sample_key_i == wk[3:0] && ((sample_val_i < 12'h190) == touch[wk]))
      cnt <= cnt + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      results;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task wr(input [3:0] a, input [15:0] x);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= x;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input [3:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task pulse;
    @(posedge core_clk_i);
    line_lock_and_sleep_pin_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    line_lock_and_sleep_pin_i <= 1'b0;
  endtask
  task press(input [9:0] x, input integer key);
    @(negedge core_clk_i);
    touch = x;
    wk = key;
    cnt = 0;
    slow = $random(seed) & 1;
  endtask
  task wait_state(input [9:0] x);
    for (i = 0; i < 4000 && key_state_o !== x; i++)
      @(posedge core_clk_i);
    #1 chk(key_state_o, x);
  endtask
  task debounce(input [7:0] c, input [31:0] on_n);
    wr(4'h0, {8'h00, c});
    k = ($random(seed) & 32'h7fff) % 10;
    press(10'h001 << k, k);
    wait_state(10'h001 << k);
    chk(cnt, on_n);
    press(10'h000, k);
    wait_state(10'h000);
    chk(cnt, 6);
  endtask
  task group(input [7:0] c, input [9:0] x, input [9:0] e);
    wr(4'h0, {8'h00, c});
    press(x, 0);
    wait_state(e);
    press(10'h000, 0);
    wait_state(10'h000);
  endtask
  initial begin
    seed = 32'h3ac2;
    {n_mismatch, tests_run, cyc, cnt, gcnt, wk} = '0;
    {nrst_i, reg_wr_i, reg_rd_i, line_lock_and_sleep_pin_i, slow} = '0;
    {reg_addr_i, reg_wdata_i, touch} = '0;
    ser_rx_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk({change_n_o, ser_tx_o, cal_done_o, key_state_o}, 13'h1800);
    nrst_i <= 1'b1;
    for (i = 0; i < 2000 && cal_done_o !== 1'b1; i++)
      @(posedge core_clk_i);
    chk(cal_done_o, 1);
    d = 16'($random(seed));
    wr(4'h0, {d[15:8], 8'h1d});
    rd(4'h0);
    chk(d, 16'h001d);
    rd(4'h8);
    chk(d, 16'h0000);
    debounce(8'h00, 6);
    debounce(8'h04, 2);
    debounce(8'h0c, 6);
    debounce(8'h84, 6);
    group(8'h08, 10'h021, 10'h020);
    group(8'h18, 10'h204, 10'h200);
    group(8'h08, 10'h204, 10'h204);
    wr(4'h0, 16'h0000);
    v = 10'($random(seed)) | 10'h001;
    press(v, 0);
    wait_state(v);
    chk(change_n_o, 0);
    b = 32 + (($random(seed) & 32'h7fff) % 16);
    @(posedge core_clk_i);
    ser_rx_i <= 1'b0;
    repeat (b) @(posedge core_clk_i);
    ser_rx_i <= 1'b1;
    for (i = 0; i < 12 * b && ser_tx_oe_o !== 1'b1; i++)
      @(posedge core_clk_i);
    repeat (b / 2) @(posedge core_clk_i);
    for (i = 0; i < 10; i++) begin
      fr = {ser_tx_o, fr[9:1]};
      repeat (b) @(posedge core_clk_i);
    end
    chk(fr, {1'b1, v[7:0], 1'b0});
    for (i = 0; i < 12 * b && ser_tx_oe_o !== 1'b0; i++)
      @(posedge core_clk_i);
    #1 chk(change_n_o, 1);
    press(10'h000, 0);
    wait_state(10'h000);
    wr(4'h0, 16'h0020);
    repeat (150) @(posedge core_clk_i);
    b = gcnt;
    repeat (150) @(posedge core_clk_i);
    chk(gcnt - b, 0);
    pulse;
    repeat (200) @(posedge core_clk_i);
    chk(gcnt - b, 3);
    wr(4'h0, 16'h0040);
    pulse;
    repeat (200) @(posedge core_clk_i);
    rd(4'h4);
    chk(d[11], 1);
    press(10'h008, 3);
    for (i = 0; i < 4000 && touch_wake_o !== 1'b1; i++)
      @(posedge core_clk_i);
    rd(4'h4);
    chk({touch_wake_o, d[11]}, 2'b10);
    press(10'h000, 3);
    wait_state(10'h000);
    pulse;
    repeat (20) @(posedge core_clk_i);
    rd(4'h4);
    chk({touch_wake_o, d[11]}, 2'b01);
    results;
  end
endmodule
